// *** common/vamc_pkg.sv ***
// constants and types for the voice activity and mute control block
// assumes one 100 MHz clock and a frame strobe already in that domain
package vamc_pkg;
    localparam int     SAMPLE_W      = 8;
    localparam int     VAC_ENABLE    = 7;
    localparam int     VAC_THR_HI    = 6;
    localparam int     VAC_THR_LO    = 5;
    localparam int     VAC_FORCE_RX  = 3;
    localparam int     VAC_NOISE_HI  = 2;
    localparam int     VAC_NOISE_LO  = 0;
    localparam int     STATUS_VOICE  = 7;
    localparam int     SLOT_MUTE_HI  = 2;
    localparam int     SLOT_MUTE_LO  = 0;
    localparam logic [7:0] VAC_RESET  = 8'h00;
    localparam logic [7:0] SLOT_RESET = 8'h00;
    // energy thresholds per two-bit select, on sample magnitude
    localparam logic [6:0] THR0 = 7'h08;
    localparam logic [6:0] THR1 = 7'h10;
    localparam logic [6:0] THR2 = 7'h20;
    localparam logic [6:0] THR3 = 7'h40;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [7:0]  SILENCE   = 8'h00;
    typedef enum logic {VAMC_NORMAL, VAMC_EXPAND} vamc_mode_t;
endpackage

// *** src/vamc_noise.sv ***
// background noise source scaled by a three-bit amplitude
// assumes a one-cycle frame strobe on the same clock
`timescale 1ns/10ps
`default_nettype none
module vamc_noise (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       step,
    input  wire logic [2:0] amp,
    output logic      [7:0] noise
);
    import vamc_pkg::*;
    typedef struct packed {
        logic [15:0] lfsr;
        logic [7:0]  noise;
    } vamc_nz_t;
    vamc_nz_t s_r;
    vamc_nz_t s_nxt;
    logic     [7:0] raw;

    always_comb begin
        s_nxt = s_r;
        raw   = s_r.lfsr[7:0] >> (3'd7 - amp);
        if (step) begin
            s_nxt.lfsr  = {s_r.lfsr[14:0],
                           s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
            // centre around zero: sign from a separate lfsr bit
            s_nxt.noise = s_r.lfsr[8] ? 8'(~raw + 8'd1) : raw;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '{lfsr: LFSR_SEED, noise: SILENCE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign noise = s_r.noise;
endmodule // vamc_noise
`default_nettype wire

// *** src/vamc_top.sv ***
// voice activity detection, receive voice gating and mute level select
// assumes samples arrive already deserialised, one per frame strobe, in clk domain
`timescale 1ns/10ps
`default_nettype none
module vamc_top (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // frame timing and samples
    input  wire logic       FRAME_STB,
    input  wire logic [7:0] EC_TX_SERIAL_IN,
    input  wire logic [7:0] EC_RX_SERIAL_IN,
    // control
    input  wire logic [7:0] VOICE_ACTIVITY_CTRL_REG,
    input  wire logic [7:0] MUTE_SLOT_CTRL_REG,
    input  wire logic       RX_VOICE_PRESENT_IN,
    input  wire logic       MUTE_EN,
    input  wire logic       MUTE_LEVEL_SEL0,
    input  wire logic       MUTE_LEVEL_SEL1,
    input  wire logic       MUTE_LEVEL_SEL2,
    input  wire logic       MODE_SELECT_STRAP,
    input  wire logic       TEST_IN_A,
    input  wire logic       TEST_IN_B,
    input  wire logic       TEST_IN_C,
    // results
    output logic            TX_VOICE_DETECT,
    output logic      [7:0] TONE_VOICE_STATUS_REG,
    output logic      [7:0] EC_RX_OUT,
    output logic      [2:0] RX_MUTE_LEVEL,
    output logic            MODE_EXPAND
);
    import vamc_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic       voice;
        logic [7:0] rx_out;
        logic [2:0] mute;
        vamc_mode_t mode;
        logic       strap_seen;
    } vamc_st_t;
    vamc_st_t s_r;
    vamc_st_t s_nxt;

    logic [7:0] noise;
    logic [6:0] mag;
    logic [6:0] thr;
    logic       vox_on;
    logic       rx_voice;
    logic       tests_idle;

    vamc_noise u_noise (
        .clk   (CLK),
        .rst   (RST),
        .step  (FRAME_STB),
        .amp   (VOICE_ACTIVITY_CTRL_REG[VAC_NOISE_HI:VAC_NOISE_LO]),
        .noise (noise)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt      = s_r;
        // test pins are expected low; any test pin high forces the voice result low
        tests_idle = ~(TEST_IN_A | TEST_IN_B | TEST_IN_C);
        vox_on     = VOICE_ACTIVITY_CTRL_REG[VAC_ENABLE];
        // sign-magnitude level of the transmit sample
        mag        = EC_TX_SERIAL_IN[6:0];
        case (VOICE_ACTIVITY_CTRL_REG[VAC_THR_HI:VAC_THR_LO])
            2'd0:    thr = THR0;
            2'd1:    thr = THR1;
            2'd2:    thr = THR2;
            default: thr = THR3;
        endcase
        rx_voice = RX_VOICE_PRESENT_IN | VOICE_ACTIVITY_CTRL_REG[VAC_FORCE_RX];
        if (FRAME_STB) begin
            // one update per frame keeps pin and status bit in step
            s_nxt.voice = vox_on && tests_idle && (mag >= thr);
            if (!vox_on || rx_voice) begin
                s_nxt.rx_out = EC_RX_SERIAL_IN;
            end else begin
                s_nxt.rx_out = noise;
            end
        end
        if (MUTE_EN) begin
            s_nxt.mute = {MUTE_LEVEL_SEL2, MUTE_LEVEL_SEL1, MUTE_LEVEL_SEL0}
                       | MUTE_SLOT_CTRL_REG[SLOT_MUTE_HI:SLOT_MUTE_LO];
        end else begin
            s_nxt.mute = 3'd0;
        end
        // strap caught once after reset release, never under reset
        if (!s_r.strap_seen) begin
            s_nxt.mode       = MODE_SELECT_STRAP ? VAMC_EXPAND : VAMC_NORMAL;
            s_nxt.strap_seen = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '{voice: 1'b0, rx_out: SILENCE, mute: 3'd0,
                     mode: VAMC_NORMAL, strap_seen: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign TX_VOICE_DETECT       = s_r.voice;
    assign TONE_VOICE_STATUS_REG = {s_r.voice, 7'd0};
    assign EC_RX_OUT             = s_r.rx_out;
    assign RX_MUTE_LEVEL         = s_r.mute;
    assign MODE_EXPAND           = (s_r.mode == VAMC_EXPAND);
endmodule // vamc_top
`default_nettype wire

// *** verification/vamc_assertions.sv ***
// port-level checks of the voice activity and mute control block
// assumes binding onto vamc_top
`timescale 1ns/10ps
`default_nettype none
module vamc_assertions (
    input wire logic CLK, RST, FRAME_STB, RX_VOICE_PRESENT_IN, MUTE_EN, TEST_IN_A,
    input wire logic TEST_IN_B, TEST_IN_C, MUTE_LEVEL_SEL0, MUTE_LEVEL_SEL1, MUTE_LEVEL_SEL2,
    input wire logic TX_VOICE_DETECT, MODE_EXPAND,
    input wire logic [2:0] RX_MUTE_LEVEL,
    input wire logic [7:0] EC_TX_SERIAL_IN, EC_RX_SERIAL_IN, VOICE_ACTIVITY_CTRL_REG,
    input wire logic [7:0] MUTE_SLOT_CTRL_REG, TONE_VOICE_STATUS_REG, EC_RX_OUT
);
    import vamc_pkg::*;
    wire logic [7:0] v = VOICE_ACTIVITY_CTRL_REG;
    logic [6:0] thr [4] = '{THR0, THR1, THR2, THR3};
    logic ps, pr, pm, pen, pv, pass;
    logic [2:0] em;
    always_ff @(posedge CLK) begin
        ps <= FRAME_STB;
        pr <= RST;
        pm <= MUTE_EN;
        pen <= v[7];
        pv <= v[7] & ~(TEST_IN_A | TEST_IN_B | TEST_IN_C) & (EC_TX_SERIAL_IN[6:0] >= thr[v[6:5]]);
        pass <= RX_VOICE_PRESENT_IN | v[3] | ~v[7];
        em <= {3{MUTE_EN}} & (MUTE_SLOT_CTRL_REG[2:0] |
            {MUTE_LEVEL_SEL2, MUTE_LEVEL_SEL1, MUTE_LEVEL_SEL0});
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    status_mirror_a: assert property (TONE_VOICE_STATUS_REG == {TX_VOICE_DETECT, 7'h00})
        else $error("status bit differs from detect pin");
    detect_value_a: assert property (ps && !pr |-> TX_VOICE_DETECT == pv)
        else $error("detect result wrong");
    detect_off_a: assert property (ps && !pr && !pen |-> !TX_VOICE_DETECT)
        else $error("detect while disabled");
    rx_pass_a: assert property (ps && !pr && pass |-> EC_RX_OUT == $past(EC_RX_SERIAL_IN))
        else $error("receive voice not passed");
    frame_hold_a: assert property (!FRAME_STB |=> $stable(TX_VOICE_DETECT) && $stable(EC_RX_OUT))
        else $error("output moved between frames");
    mute_level_a: assert property (!pr |-> RX_MUTE_LEVEL == em)
        else $error("mute level wrong");
    mute_off_a: assert property (!pr && !pm |-> RX_MUTE_LEVEL == 3'h0)
        else $error("mute level while disabled");
    mode_hold_a: assert property (!pr && !$past(pr) |-> $stable(MODE_EXPAND))
        else $error("mode changed after reset");
endmodule // vamc_assertions
bind vamc_top vamc_assertions chk_u (.*);
`default_nettype wire

// *** verification/vamc_partner.sv ***
// far-side model: one frame sync source and the two sample lines
// assumes the bench sets sample levels; drives on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module vamc_partner #(parameter int PER = 8) (
    input  wire logic       clk,
    input  wire logic [7:0] tx,
    input  wire logic [7:0] rx,
    output logic            stb,
    output logic      [7:0] txd,
    output logic      [7:0] rxd
);
    int n = 0;
    initial {stb, txd, rxd} = '0;
    // a single sync source, so the order of sync edges never changes
    always @(negedge clk) begin
        n = (n + 1) % PER;
        stb <= n == 0;
        // lines show junk outside the sample slot to expose late sampling
        txd <= n == 0 ? tx : ~tx;
        rxd <= n == 0 ? rx : ~rx;
    end
endmodule // vamc_partner
`default_nettype wire

// *** verification/vamc_tb_top.sv ***
// self-checking bench for vamc_top with the far-side model
// assumes vamc_pkg compiled first
`timescale 1ns/10ps
`default_nettype none
module vamc_tb_top;
    import vamc_pkg::*;
    logic clk = 0, rst = 1, rxv = 0, men = 0, s0 = 0, s1 = 0, s2 = 0, strap = 0, ta = 0;
    logic [7:0] tx = 0, rx = 0, vac = 0, msc = 0, txd, rxd, stat, rout;
    logic stb, det, mexp;
    logic [2:0] mlv;
    int mismatches = 0, checks = 0, cyc = 0;
    logic [6:0] thr [4] = '{THR0, THR1, THR2, THR3};
    vamc_partner #(.PER(8)) far_u (.clk(clk), .tx(tx), .rx(rx), .stb(stb), .txd(txd), .rxd(rxd));
    vamc_top dut_u (.CLK(clk), .RST(rst), .FRAME_STB(stb), .EC_TX_SERIAL_IN(txd),
        .EC_RX_SERIAL_IN(rxd), .VOICE_ACTIVITY_CTRL_REG(vac), .MUTE_SLOT_CTRL_REG(msc),
        .RX_VOICE_PRESENT_IN(rxv), .MUTE_EN(men), .MUTE_LEVEL_SEL0(s0), .MUTE_LEVEL_SEL1(s1),
        .MUTE_LEVEL_SEL2(s2), .MODE_SELECT_STRAP(strap), .TEST_IN_A(ta), .TEST_IN_B(1'b0),
        .TEST_IN_C(1'b0), .TX_VOICE_DETECT(det), .TONE_VOICE_STATUS_REG(stat),
        .EC_RX_OUT(rout), .RX_MUTE_LEVEL(mlv), .MODE_EXPAND(mexp));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin mismatches++; stop_test(); end
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin mismatches++; $display("[ERR] %0t seen %h exp %h", $time, s, e); end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // outputs of a frame are settled once the strobe has fallen
    task fr; @(negedge stb); endtask
    task t_reset(input logic s);
        strap = s;
        rst = 1;
        repeat (3) @(negedge clk);
        chk(stat, 8'h00);
        rst = 0;
        repeat (2) @(negedge clk);
        chk(8'(mexp), 8'(s));
    endtask
    task t_thr;
        for (int i = 0; i < 4; i++) for (int d = 0; d < 2; d++) begin
            vac = {1'b1, 2'(i), 5'h00};
            tx = {1'(i), 7'(thr[i] + d - 1)};
            fr;
            chk(8'(det), 8'(d));
            chk(stat, {1'(d), 7'h00});
        end
    endtask
    task t_off;
        tx = 8'h7F;
        vac = 8'h00;
        fr;
        chk(8'(det), 8'h00);
        vac = 8'h80;
        ta = 1;
        fr;
        chk(8'(det), 8'h00);
        ta = 0;
    endtask
    task t_rx;
        logic dif;
        dif = 0;
        rx = 8'h5A;
        {vac, rxv} = {8'h87, 1'b1};
        fr;
        chk(rout, 8'h5A);
        {vac, rxv} = {8'h8F, 1'b0};
        fr;
        chk(rout, 8'h5A);
        vac = 8'h87;
        repeat (4) begin fr; dif |= rout !== 8'h5A; end
        chk(8'(dif), 8'h01);
    endtask
    task t_mute;
        for (int i = 0; i < 16; i++) begin
            men = i[3];
            {s2, s1, s0} = 3'(i) & 3'h5;
            msc = 8'(i & 3);
            @(negedge clk);
            chk(8'(mlv), i[3] ? 8'(i[2:0]) : 8'h00);
        end
    endtask
    initial begin
        t_reset(0);
        t_thr;
        t_off;
        t_rx;
        t_mute;
        t_reset(1);
        stop_test;
    end
endmodule // vamc_tb_top
`default_nettype wire
